// File: rtl/ast_ctrl.sv
// Trigger gating, scan sequencing, strap readback and cascadable interval timer
//
// Behaviour
// - A low external trigger starts one conversion or a whole scan, by the conversion mode.
// - The external trigger counts only while control bit D11 is set.
// - The trigger-ready output is high whenever the external-start enable is set.
// - The interval timer is one 48-bit counter split into three 16-bit stages.
// - The counters cascade to give 16, 32 or 48 bit count lengths.
// - Every scanning mode takes its channel count from the scan-length straps.
// - A scan starts at channel 0 and steps by one until the converted count equals the setting.
// - A setting of 64 converts channels 0 to 63 and is the default.
// - The scan length is a seven-bit binary count with weights 1 to 64.
// - A scan-length strap reads zero when fitted and one when absent.
// - The configuration register is read-only and its low five bits show the straps.
// - Bit D4 reads one unless fitted; zero is unipolar, one is bipolar.
// - Bit D3 reads one unless fitted; zero is 10V range, one is 20V range.
// - Bits D2..D0 encode gain x1, x10, x100, x200, x500 as 000 to 100.
`timescale 1ns/1ns
`include "ast_cfg.svh"
module ast_ctrl
  import ast_pkg::*;
#(
  parameter int CONV_CYCLES = `AST_CONV_CYCLES
) (
  input wire logic clk, // 20 MHz board clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [15:0] ctrl_reg, // Control register contents from software
  input wire logic scan_mode_sel, // 1 = scanning mode, 0 = single conversion
  input wire logic ext_convert_trigger_n, // External start, active low
  input wire logic [6:0] scan_length_straps, // Absent strap reads one
  input wire logic [4:0] config_straps, // Fitted strap reads zero
  input wire ast_tmr_cfg_t tmr_cfg, // Timer load, run and length select
  output logic ext_trigger_ready_out, // High when external start enabled
  output logic conv_start, // One-cycle pulse per conversion
  output logic [5:0] conv_chan, // Channel being converted
  output logic scan_busy, // High while a conversion or scan runs
  output logic [15:0] config_strap_reg, // Read-only strap readback
  output logic tmr_tick // One-cycle pulse at timer terminal count
);
  // Start pulse to busy low for a single conversion: conversion time plus the step cycle
  localparam int SINGLE_SPAN = CONV_CYCLES + 1;

  ast_state_s_t s_r, s_nxt;
  logic ext_en;
  logic trig_fall;
  logic [47:0] tmr_mask;
  logic [2:0] stage_zero;
  logic tmr_term;
  logic [6:0] scan_len;

  assign ext_en = ctrl_reg[`AST_CTRL_EXT_EN_BIT];
  // Straps are taken raw: a fitted strap already pulls its bit to zero
  assign scan_len = scan_length_straps;
  // Armed clears on the taken edge and sets again only after a high sample,
  // so a trigger held low for many cycles starts one conversion or one scan only
  assign trig_fall = s_r.trig_armed && !s_r.trig_s2 && ext_en;

  // One zero detector per 16-bit stage; cascading only widens the set that must agree
  for (genvar g = 0; g < 3; g++) begin : g_stage
    assign stage_zero[g] = (s_r.tmr[16*g +: 16] == 16'h0000);
  end

  // Length select; changing it while running can leave a long first period
  always_comb begin
    unique case (tmr_cfg.len)
      `AST_TMR_LEN_32: begin
        tmr_mask = {16'h0000, 32'hFFFFFFFF};
        tmr_term = &stage_zero[1:0];
      end
      `AST_TMR_LEN_48: begin
        tmr_mask = 48'hFFFFFFFFFFFF;
        tmr_term = &stage_zero;
      end
      default: begin
        tmr_mask = {32'h00000000, 16'hFFFF};
        tmr_term = stage_zero[0];
      end
    endcase
  end

  // Synchroniser, scan sequencer and timer all update one state copy
  always_comb begin
    s_nxt = s_r;
    s_nxt.conv_start = 1'b0;
    s_nxt.tmr_tick = 1'b0;
    s_nxt.trig_s1 = ext_convert_trigger_n;
    s_nxt.trig_s2 = s_r.trig_s1;
    s_nxt.ready = ext_en;
    s_nxt.cfg_rd = {`AST_CFG_FIXED_HI, config_straps};
    if (s_r.trig_s2) s_nxt.trig_armed = 1'b1;
    if (trig_fall) s_nxt.trig_armed = 1'b0;
    unique case (s_r.st)
      AST_IDLE: begin
        // A zero scan length would still run one conversion before ending, so it is refused here
        if (trig_fall && (!scan_mode_sel || scan_len != 7'h00)) begin
          s_nxt.scan_mode = scan_mode_sel;
          s_nxt.chan = 7'h00;
          s_nxt.done_cnt = 7'h00;
          s_nxt.conv_cnt = 8'h00;
          s_nxt.conv_start = 1'b1;
          s_nxt.scan_busy = 1'b1;
          s_nxt.st = AST_CONV;
        end
      end
      AST_CONV: begin
        // Count out the conversion time, then step
        s_nxt.conv_cnt = s_r.conv_cnt + 8'h01;
        if (s_r.conv_cnt == 8'(CONV_CYCLES - 1)) begin
          s_nxt.done_cnt = s_r.done_cnt + 7'h01;
          s_nxt.st = AST_NEXT;
        end
      end
      AST_NEXT: begin
        // done_cnt already includes the conversion that just ended
        if (!s_r.scan_mode || s_r.done_cnt >= scan_len) begin
          s_nxt.scan_busy = 1'b0;
          s_nxt.st = AST_IDLE;
        end else begin
          s_nxt.chan = s_r.chan + 7'h01;
          s_nxt.conv_cnt = 8'h00;
          s_nxt.conv_start = 1'b1;
          s_nxt.st = AST_CONV;
        end
      end
      default: s_nxt.st = AST_IDLE;
    endcase
    // Holding the load value while stopped makes the first period exact at the 16-bit length only
    if (!tmr_cfg.run) begin
      s_nxt.tmr = {32'h00000000, tmr_cfg.load};
    end else if (tmr_term) begin
      s_nxt.tmr_tick = 1'b1;
      s_nxt.tmr = {tmr_cfg.load, tmr_cfg.load, tmr_cfg.load} & tmr_mask;
    end else begin
      s_nxt.tmr = (s_r.tmr - 48'h000000000001) & tmr_mask;
    end
  end

  // Reset parks the synchroniser high, so a pin low at release is seen as a falling edge and taken as a start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: AST_IDLE, trig_s1: 1'b1, trig_s2: 1'b1, cfg_rd: `AST_CFG_RST_VAL,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is a register bit
  // Lengths above 64 run past the last channel and wrap the six-bit number
  assign ext_trigger_ready_out = s_r.ready;
  assign conv_start = s_r.conv_start;
  assign conv_chan = s_r.chan[5:0];
  assign scan_busy = s_r.scan_busy;
  assign config_strap_reg = s_r.cfg_rd;
  assign tmr_tick = s_r.tmr_tick;

  // Trigger path
  ready_follow_a: assert property (@(posedge clk) disable iff (rst)
    ext_trigger_ready_out == $past(ext_en))
    else $error("ready does not follow enable");
  trig_gate_a: assert property (@(posedge clk) disable iff (rst)
    (!ext_en && s_r.st == AST_IDLE) |=> !conv_start)
    else $error("start while disabled");
  once_per_a: assert property (@(posedge clk) disable iff (rst)
    trig_fall |=> !trig_fall)
    else $error("trigger taken twice");
  taken_start_a: assert property (@(posedge clk) disable iff (rst)
    (trig_fall && s_r.st == AST_IDLE && (!scan_mode_sel || scan_len != 7'h00))
      |=> (conv_start && scan_busy))
    else $error("taken trigger did not start");
  conv_pulse_a: assert property (@(posedge clk) disable iff (rst)
    conv_start |=> !conv_start)
    else $error("start pulse too long");
  busy_with_start_a: assert property (@(posedge clk) disable iff (rst)
    conv_start |-> scan_busy)
    else $error("start without busy");
  // A single conversion releases busy one conversion time plus the step cycle after it rises
  single_span_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(scan_busy) && !s_r.scan_mode) |-> ##SINGLE_SPAN $fell(scan_busy))
    else $error("single conversion length wrong");

  // Scan sequencing
  start_chan0_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(scan_busy)) |-> conv_chan == 6'h00)
    else $error("scan not at channel 0");
  chan_step_a: assert property (@(posedge clk) disable iff (rst)
    (conv_start && !$rose(scan_busy)) |-> conv_chan == $past(conv_chan, 2) + 6'h01)
    else $error("channel did not step by one");
  chan_limit_a: assert property (@(posedge clk) disable iff (rst)
    (conv_start && s_r.scan_mode) |-> s_r.chan < $past(scan_len))
    else $error("channel beyond scan length");
  scan_end_a: assert property (@(posedge clk) disable iff (rst)
    $fell(scan_busy) && $past(s_r.scan_mode) |-> $past(s_r.done_cnt) >= $past(scan_len))
    else $error("scan ended early");
  scan_stop_a: assert property (@(posedge clk) disable iff (rst)
    $fell(scan_busy) |-> $past(s_r.st) == AST_NEXT)
    else $error("busy dropped mid conversion");

  // Strap readback and timer
  cfg_read_a: assert property (@(posedge clk) disable iff (rst)
    config_strap_reg == {`AST_CFG_FIXED_HI, $past(config_straps)})
    else $error("strap readback wrong");
  tmr_reload_a: assert property (@(posedge clk) disable iff (rst)
    tmr_tick |-> $past(tmr_cfg.run))
    else $error("tick while stopped");

  // Main scenarios
  cv_scan_c: cover property (@(posedge clk) disable iff (rst)
    $fell(scan_busy) && s_r.done_cnt == 7'h40);
  cv_single_c: cover property (@(posedge clk) disable iff (rst)
    $rose(scan_busy) && !scan_mode_sel);
  cv_tick_c: cover property (@(posedge clk) disable iff (rst)
    tmr_tick);
  cv_cascade_c: cover property (@(posedge clk) disable iff (rst)
    tmr_tick && tmr_cfg.len == `AST_TMR_LEN_32);
  cv_refused_c: cover property (@(posedge clk) disable iff (rst)
    s_r.trig_armed && !s_r.trig_s2 && !ext_en);
endmodule // ast_ctrl

// File: shared/ast_cfg.svh
// Constants for the scan, trigger and strap control block
`ifndef AST_CFG_SVH
`define AST_CFG_SVH
`define AST_CTRL_EXT_EN_BIT 11
`define AST_CTRL_RST_VAL 16'h0000
`define AST_CFG_FIXED_HI 11'h000
`define AST_CFG_RST_VAL 16'h001F
`define AST_SCAN_LEN_DEFAULT 7'h40
`define AST_TMR_W 16
`define AST_TMR_LEN_16 2'h0
`define AST_TMR_LEN_32 2'h1
`define AST_TMR_LEN_48 2'h2
`define AST_CONV_CYCLES 8'h04
`endif

// File: shared/ast_pkg.sv
// Types for the scan, trigger and strap control block
package ast_pkg;
  typedef enum logic [2:0] {
    AST_IDLE = 3'b001,
    AST_CONV = 3'b010,
    AST_NEXT = 3'b100
  } ast_state_t;

  typedef struct packed {
    logic [15:0] load;
    logic        run;
    logic [1:0]  len;
  } ast_tmr_cfg_t;

  typedef struct packed {
    ast_state_t  st;
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_armed;
    logic        scan_mode;
    logic [6:0]  chan;
    logic [6:0]  done_cnt;
    logic [7:0]  conv_cnt;
    logic        conv_start;
    logic        scan_busy;
    logic        ready;
    logic [15:0] cfg_rd;
    logic [47:0] tmr;
    logic        tmr_tick;
  } ast_state_s_t;
endpackage

// File: sim/ast_ctrl_tb_top.sv
// Testbench for the scan, trigger and strap control block
`timescale 1ns/1ns
`include "ast_cfg.svh"
module ast_ctrl_tb_top;
  import ast_pkg::*;
  logic clk = 0, rst = 1, mode = 1, fire = 0, rude = 0;
  logic [15:0] ctrl = 16'h0000;
  logic [6:0] len = `AST_SCAN_LEN_DEFAULT;
  logic [4:0] cfg = 5'h1F;
  ast_tmr_cfg_t tcfg = '0;
  logic rdy, cs, busy, tick, trig_n;
  logic [5:0] chan;
  logic [15:0] config_strap_readback;
  int num_errors = 0, tests_run = 0, seed = 95270, nconv = 0, i, t;
  always #25 clk = ~clk;
  ast_ctrl dut (.clk(clk), .rst(rst), .ctrl_reg(ctrl), .scan_mode_sel(mode),
    .ext_convert_trigger_n(trig_n), .scan_length_straps(len), .config_straps(cfg),
    .tmr_cfg(tcfg), .ext_trigger_ready_out(rdy), .conv_start(cs), .conv_chan(chan),
    .scan_busy(busy), .config_strap_reg(config_strap_readback), .tmr_tick(tick));
  ast_trig_model partner (.clk(clk), .ready(rdy), .fire(fire), .rude(rude), .trig_n(trig_n));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Conversions per trigger: the whole scan length, or one in single mode
  function automatic logic [15:0] exp_convs(input logic m, input logic [6:0] l);
    return m ? {9'h000, l} : 16'h0001;
  endfunction
  // A 16-bit stage counts load down to zero, then reloads
  function automatic logic [15:0] exp_period(input logic [15:0] ld);
    return ld + 16'h0001;
  endfunction
  // Conversions must come on channels 0, 1, 2 ... in order
  always @(negedge clk) if (cs === 1'b1) begin
    chk("chan", nconv[15:0], {10'h0, chan});
    nconv++;
  end
  task automatic shot(input string nm, input logic [15:0] e);
    nconv = 0;
    repeat (3) @(negedge clk);
    fire = 1;
    @(negedge clk) fire = 0;
    repeat (10) @(negedge clk);
    for (t = 0; busy !== 1'b0; t++) begin
      if (t > 1000) begin
        num_errors++;
        $display("mismatch %s expected idle seen busy", nm);
        conclude();
      end
      @(negedge clk);
    end
    repeat (8) @(negedge clk);
    chk(nm, e, nconv[15:0]);
    $display("test %s done", nm);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    for (i = 0; i < 8; i++) begin
      cfg = 5'($random(seed));
      ctrl = 16'($random(seed));
      repeat (2) @(negedge clk);
      chk("cfr", {11'h000, cfg}, config_strap_readback);
      chk("ready", {15'h0, ctrl[`AST_CTRL_EXT_EN_BIT]}, {15'h0, rdy});
    end
    $display("test straps done");
    ctrl = 16'h0000;
    rude = 1;
    shot("disabled", 16'h0000);
    rude = 0;
    ctrl = 16'h0800;
    shot("scan64", exp_convs(mode, len));
    len = 7'h01;
    shot("scanone", exp_convs(mode, len));
    len = 7'h00;
    shot("scanzero", exp_convs(mode, len));
    for (i = 0; i < 4; i++) begin
      len = 7'h01 + 7'($unsigned($random(seed)) % 20);
      shot("scanlen", exp_convs(mode, len));
    end
    mode = 0;
    shot("single", exp_convs(mode, len));
    tcfg = {16'h0005, 1'b1, `AST_TMR_LEN_16};
    for (t = 0; t < 40 && tick !== 1'b1; t++) @(negedge clk);
    chk("tick", 16'h0001, {15'h0, tick});
    @(negedge clk);
    for (t = 1; t < 40 && tick !== 1'b1; t++) @(negedge clk);
    chk("period16", exp_period(16'h0005), 16'(t));
    tcfg = {16'h0002, 1'b0, `AST_TMR_LEN_32};
    @(negedge clk) tcfg.run = 1'b1;
    for (t = 0; t < 40 && tick !== 1'b1; t++) @(negedge clk);
    chk("tick32", 16'h0001, {15'h0, tick});
    i = 0;
    repeat (200) @(negedge clk) if (tick === 1'b1) i++;
    chk("quiet32", 16'h0000, 16'(i));
    $display("test timer done");
    conclude();
  end
endmodule // ast_ctrl_tb_top

// File: sim/ast_trig_model.sv
// Model of the external trigger equipment
`timescale 1ns/1ns
module ast_trig_model (
  input wire logic clk, // Board clock
  input wire logic ready, // Trigger-ready from the board
  input wire logic fire, // Request one trigger
  input wire logic rude, // Fire without waiting for ready
  output logic trig_n // Trigger to the board, active low
);
  initial trig_n = 1'b1;
  always @(posedge clk) begin
    if (fire && (ready || rude)) begin
      @(negedge clk) trig_n <= 1'b0;
      repeat (3) @(negedge clk);
      trig_n <= 1'b1;
    end
  end
endmodule // ast_trig_model
